/* lmrts_top.v */
// line standard select and receive termination control, 17 channels
// assumes open pins read high (pull-ups) and a one-cycle strobe register port
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lmrts_defines.vh"

//Contract
// - line standard chosen globally or per channel via channel standard bit 0.
// - enable pin open: level pin picks standard, open T1/J1, low E1.
// - enable pin low: level pin ignored, bit 0 gives T1/J1, 1 gives E1.
// - single-ended select bit 3 picks differential or single-ended reception.
// - differential uses tip and ring; single-ended uses tip only.
// - force pin low: all 17 receivers external, per-channel bits ignored.
// - force pin high: each receiver follows its own code and split bit.
// - code bit 2 and single-ended bit 3 clear enable internal; split bit 4 picks partial or full.
// - code bit 2 set gives external; split and low bits ignored.
// - low code bits pick 100, 110, 120 or 75 ohm internal resistor.
module lmrts_top (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [`LMRTS_ADDR_W-1:0] ADDR,
  input wire [`LMRTS_DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`LMRTS_DATA_W-1:0] RDATA,
  input wire HW_STANDARD_SELECT_ENABLE_PIN,
  input wire HW_STANDARD_LEVEL_PIN,
  input wire GLOBAL_TERMINATION_FORCE_PIN,
  output wire [`LMRTS_NCH-1:0] CH_E1,
  output wire [`LMRTS_NCH-1:0] RX_SINGLE_ENDED,
  output wire [`LMRTS_NCH-1:0] RX_TIP_INPUT_USE,
  output wire [`LMRTS_NCH-1:0] RX_RING_INPUT_USE,
  output wire [`LMRTS_NCH-1:0] TERM_INTERNAL,
  output wire [`LMRTS_NCH-1:0] TERM_FULL_INTERNAL,
  output wire [2*`LMRTS_NCH-1:0] INTERNAL_PROGRAMMABLE_RESISTOR_CODE
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0] pin_meta;
  reg [2:0] pin_sync;

  // force pin takes effect in three edges, one more than register writes take
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= 3'h6;
      pin_sync <= 3'h6;
    end else begin
      pin_meta <= {HW_STANDARD_SELECT_ENABLE_PIN, HW_STANDARD_LEVEL_PIN,
                   GLOBAL_TERMINATION_FORCE_PIN};
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [`LMRTS_NCH-1:0] channel_config_register;
  reg [`LMRTS_RX_CFG0_W-1:0] rx_config_register0 [0:`LMRTS_NCH-1];

  wire [2:0] region;
  wire [4:0] ch_sel;
  wire ch_ok;
  integer i;

  assign region = ADDR[7:5];
  assign ch_sel = ADDR[4:0];
  assign ch_ok = (ch_sel <= `LMRTS_LAST_CH);

  // only the addressed channel changes
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      channel_config_register <= {`LMRTS_NCH{`LMRTS_CHAN_CFG_RESET}};
      for (i = 0; i < `LMRTS_NCH; i = i + 1) begin
        rx_config_register0[i] <= `LMRTS_RX_CFG0_RESET;
      end
    end else if (WR && ch_ok) begin
      if (region == `LMRTS_REGION_CHAN_CFG) begin
        channel_config_register[ch_sel] <= WDATA[`LMRTS_CHAN_CFG_STD];
      end
      if (region == `LMRTS_REGION_RX_CFG0) begin
        rx_config_register0[ch_sel] <= WDATA[`LMRTS_RX_CFG0_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // per-channel decode
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LMRTS_NCH; g = g + 1) begin : gen_ch
      lmrts_chan u_chan (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .std_enable_open(pin_sync[2]),
        .std_level_open(pin_sync[1]),
        .force_high(pin_sync[0]),
        .std_bit(channel_config_register[g]),
        .rx_cfg(rx_config_register0[g]),
        .e1(CH_E1[g]),
        .single(RX_SINGLE_ENDED[g]),
        .tip_use(RX_TIP_INPUT_USE[g]),
        .ring_use(RX_RING_INPUT_USE[g]),
        .internal(TERM_INTERNAL[g]),
        .full(TERM_FULL_INTERNAL[g]),
        .code(INTERNAL_PROGRAMMABLE_RESISTOR_CODE[2*g+1:2*g])
      );
    end
  endgenerate

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [`LMRTS_DATA_W-1:0] rd_value;

  // unmapped addresses and reserved bits read as zero
  always @* begin
    rd_value = `LMRTS_RDATA_IDLE;
    if (ch_ok) begin
      case (region)
        `LMRTS_REGION_CHAN_CFG: begin
          rd_value[`LMRTS_CHAN_CFG_STD] = channel_config_register[ch_sel];
        end
        `LMRTS_REGION_RX_CFG0: begin
          rd_value[`LMRTS_RX_CFG0_W-1:0] = rx_config_register0[ch_sel];
        end
        `LMRTS_REGION_STAT: begin
          rd_value[`LMRTS_STAT_E1] = CH_E1[ch_sel];
          rd_value[`LMRTS_STAT_SINGLE] = RX_SINGLE_ENDED[ch_sel];
          rd_value[`LMRTS_STAT_INTERNAL] = TERM_INTERNAL[ch_sel];
          rd_value[`LMRTS_STAT_FULL] = TERM_FULL_INTERNAL[ch_sel];
          rd_value[`LMRTS_STAT_CODE_LO] =
            INTERNAL_PROGRAMMABLE_RESISTOR_CODE[{ch_sel, 1'b0}];
          rd_value[`LMRTS_STAT_CODE_LO+1] =
            INTERNAL_PROGRAMMABLE_RESISTOR_CODE[{ch_sel, 1'b1}];
        end
        default: begin
          rd_value = `LMRTS_RDATA_IDLE;
        end
      endcase
    end
  end

  // data stand only in the cycle after the strobe
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= `LMRTS_RDATA_IDLE;
    end else if (RD) begin
      RDATA <= rd_value;
    end else begin
      RDATA <= `LMRTS_RDATA_IDLE;
    end
  end

endmodule // lmrts_top
`default_nettype wire

/* lmrts_defines.vh */
// constants for the line mode and receive termination select block
// assumes the includer uses plain verilog-2005 and an 8-bit register port
`ifndef LMRTS_DEFINES_VH
`define LMRTS_DEFINES_VH

// ----------------------------------------
// sizes
// ----------------------------------------
`define LMRTS_NCH 17
`define LMRTS_ADDR_W 8
`define LMRTS_DATA_W 8

// ----------------------------------------
// address map: region in addr[7:5], channel in addr[4:0]
// ----------------------------------------
`define LMRTS_REGION_CHAN_CFG 3'h0
`define LMRTS_REGION_RX_CFG0 3'h1
`define LMRTS_REGION_STAT 3'h2
`define LMRTS_LAST_CH 5'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define LMRTS_CHAN_CFG_STD 0
`define LMRTS_RX_CFG0_TERM_LO 0
`define LMRTS_RX_CFG0_TERM_HI 2
`define LMRTS_RX_CFG0_SINGLE 3
`define LMRTS_RX_CFG0_SPLIT 4
`define LMRTS_RX_CFG0_W 5
`define LMRTS_STAT_E1 0
`define LMRTS_STAT_SINGLE 1
`define LMRTS_STAT_INTERNAL 2
`define LMRTS_STAT_FULL 3
`define LMRTS_STAT_CODE_LO 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define LMRTS_CHAN_CFG_RESET 1'b0
`define LMRTS_RX_CFG0_RESET 5'h04
`define LMRTS_RDATA_IDLE 8'h00

`endif

/* lmrts_chan.v */
// per-channel decode of line standard and receive termination
// assumes all inputs are already on the CLK_SYS domain
`timescale 1ns/1ps
`default_nettype none
`include "lmrts_defines.vh"

module lmrts_chan (
  input wire clk,
  input wire rst_n,
  input wire std_enable_open,
  input wire std_level_open,
  input wire force_high,
  input wire std_bit,
  input wire [`LMRTS_RX_CFG0_W-1:0] rx_cfg,
  output reg e1,
  output reg single,
  output reg tip_use,
  output reg ring_use,
  output reg internal,
  output reg full,
  output reg [1:0] code
);

  wire term_ext_req;
  wire next_internal;

  // ----------------------------------------
  // termination decode
  // ----------------------------------------
  // single-ended reception supports external matching only
  assign term_ext_req = rx_cfg[`LMRTS_RX_CFG0_TERM_HI] | rx_cfg[`LMRTS_RX_CFG0_SINGLE];
  assign next_internal = force_high & ~term_ext_req;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e1 <= 1'b0;
      single <= 1'b0;
      tip_use <= 1'b1;
      ring_use <= 1'b1;
      internal <= 1'b0;
      full <= 1'b0;
      code <= 2'h0;
    end else begin
      if (std_enable_open) begin
        e1 <= ~std_level_open;
      end else begin
        e1 <= std_bit;
      end
      single <= rx_cfg[`LMRTS_RX_CFG0_SINGLE];
      tip_use <= 1'b1;
      ring_use <= ~rx_cfg[`LMRTS_RX_CFG0_SINGLE];
      internal <= next_internal;
      full <= next_internal & rx_cfg[`LMRTS_RX_CFG0_SPLIT];
      // code forced to zero when unused, so 1xx all look alike
      if (next_internal) begin
        code <= rx_cfg[`LMRTS_RX_CFG0_TERM_LO+1:`LMRTS_RX_CFG0_TERM_LO];
      end else begin
        code <= 2'h0;
      end
    end
  end

endmodule // lmrts_chan
`default_nettype wire

/* lmrts_monitor.sv */
// checker for the termination select top
// assumes it is bound into lmrts_top; open pins read high
`timescale 1ns/1ps
`default_nettype none
module lmrts_monitor (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic HW_STANDARD_SELECT_ENABLE_PIN,
  input wire logic HW_STANDARD_LEVEL_PIN,
  input wire logic GLOBAL_TERMINATION_FORCE_PIN,
  input wire logic [16:0] CH_E1,
  input wire logic [16:0] RX_SINGLE_ENDED,
  input wire logic [16:0] RX_TIP_INPUT_USE,
  input wire logic [16:0] RX_RING_INPUT_USE,
  input wire logic [16:0] TERM_INTERNAL,
  input wire logic [16:0] TERM_FULL_INTERNAL
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // pins pass two syncs, so only judge after four quiet cycles
  wire logic [2:0] pins = {HW_STANDARD_SELECT_ENABLE_PIN, HW_STANDARD_LEVEL_PIN,
    GLOBAL_TERMINATION_FORCE_PIN};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_calm; (!WR && $stable(pins)) [*4]; endsequence
  sequence s_drop; $fell(GLOBAL_TERMINATION_FORCE_PIN) ##1 !GLOBAL_TERMINATION_FORCE_PIN [*2];
  endsequence
  AST_TIP: assert property (&RX_TIP_INPUT_USE) else $error("tip unused");
  AST_RING: assert property (RX_RING_INPUT_USE == ~RX_SINGLE_ENDED) else $error("ring");
  AST_SNG: assert property ((TERM_INTERNAL & RX_SINGLE_ENDED) == 17'h0) else $error("sng");
  AST_FULL: assert property ((TERM_FULL_INTERNAL & ~TERM_INTERNAL) == 17'h0) else $error("full");
  AST_FORCE: assert property (s_calm ##0 !GLOBAL_TERMINATION_FORCE_PIN |->
    TERM_INTERNAL == 17'h0) else $error("force");
  AST_DROP: assert property (s_drop |=> TERM_INTERNAL == 17'h0) else $error("drop");
  AST_GLB: assert property (s_calm ##0 HW_STANDARD_SELECT_ENABLE_PIN |->
    CH_E1 == {17{!HW_STANDARD_LEVEL_PIN}}) else $error("global");
  AST_RD: assert property (!RD |=> RDATA == 8'h00) else $error("rdata idle");
endmodule // lmrts_monitor
bind lmrts_top lmrts_monitor i_mon (.*);
`default_nettype wire

/* lmrts_pins.sv */
// pin model: straps and force pin with pull-ups
// assumes a low request grounds the pin, otherwise it floats high
`timescale 1ns/1ps
`default_nettype none
module lmrts_pins (
  input wire logic en_lo,
  input wire logic lvl_lo,
  input wire logic frc_lo,
  output logic en_pin,
  output logic lvl_pin,
  output logic frc_pin
);
  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  // bench keeps frc_lo set through reset for a safe power-up
  assign en_pin = ~en_lo;
  assign lvl_pin = ~lvl_lo;
  assign frc_pin = ~frc_lo;
endmodule // lmrts_pins
`default_nettype wire

/* lmrts_top_tb.sv */
// self-checking bench for the termination select top
// assumes the pin model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module lmrts_top_tb;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  logic CLK_SYS = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
  logic en_lo = 1'b0, lvl_lo = 1'b0, frc_lo = 1'b1;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
  wire logic [7:0] RDATA;
  wire logic HW_STANDARD_SELECT_ENABLE_PIN, HW_STANDARD_LEVEL_PIN, GLOBAL_TERMINATION_FORCE_PIN;
  wire logic [16:0] CH_E1, RX_SINGLE_ENDED, RX_TIP_INPUT_USE, RX_RING_INPUT_USE;
  wire logic [16:0] TERM_INTERNAL, TERM_FULL_INTERNAL;
  wire logic [33:0] INTERNAL_PROGRAMMABLE_RESISTOR_CODE;
  // lines have transformers, so full internal is allowed
  logic [7:0] cfg [6] = '{8'h00, 8'h11, 8'h02, 8'h13, 8'h07, 8'h08};
  int failures = 0;
  int total_checks = 0;
  initial forever #5 CLK_SYS = ~CLK_SYS;
  lmrts_pins i_pins (.en_lo(en_lo), .lvl_lo(lvl_lo), .frc_lo(frc_lo),
    .en_pin(HW_STANDARD_SELECT_ENABLE_PIN), .lvl_pin(HW_STANDARD_LEVEL_PIN),
    .frc_pin(GLOBAL_TERMINATION_FORCE_PIN));
  lmrts_top i_dut (.*);
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic st;
    repeat (6) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(negedge CLK_SYS);
    chk("rdata", RDATA, e);
  endtask
  task automatic pn(input logic a, input logic b, input logic c);
    @(posedge CLK_SYS);
    en_lo <= a;
    lvl_lo <= b;
    frc_lo <= c;
    st();
  endtask
  task automatic t_std;
    pn(1'b1, 1'b0, 1'b1);
    for (int n = 0; n < 17; n++) wr(n[7:0], {7'h0, n[0]});
    st();
    chk("e1", CH_E1, 34'h0AAAA);
    pn(1'b1, 1'b1, 1'b1);
    chk("e1", CH_E1, 34'h0AAAA);
    pn(1'b0, 1'b1, 1'b1);
    chk("e1", CH_E1, 34'h1FFFF);
    pn(1'b0, 1'b0, 1'b1);
    chk("e1", CH_E1, 34'h00000);
    rd(8'h01, 8'h01);
  endtask
  task automatic t_term;
    rd(8'h20, 8'h04);
    for (int n = 0; n < 6; n++) wr(8'h20 + n[7:0], cfg[n]);
    pn(1'b0, 1'b0, 1'b0);
    chk("int", TERM_INTERNAL, 34'h0000F);
    chk("full", TERM_FULL_INTERNAL, 34'h0000A);
    chk("code", INTERNAL_PROGRAMMABLE_RESISTOR_CODE, 34'h000E4);
    chk("sng", RX_SINGLE_ENDED, 34'h00020);
    chk("ring", RX_RING_INPUT_USE, 34'h1FFDF);
    chk("tip", RX_TIP_INPUT_USE, 34'h1FFFF);
    rd(8'h43, 8'h3C);
    wr(8'h31, 8'h00);
    wr(8'hE0, 8'h1F);
    rd(8'hE0, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h23, 8'h13);
    st();
    chk("int", TERM_INTERNAL, 34'h0000F);
    chk("full", TERM_FULL_INTERNAL, 34'h0000A);
    pn(1'b0, 1'b0, 1'b1);
    chk("int", TERM_INTERNAL, 34'h00000);
    chk("full", TERM_FULL_INTERNAL, 34'h00000);
    chk("code", INTERNAL_PROGRAMMABLE_RESISTOR_CODE, 34'h0);
    pn(1'b0, 1'b0, 1'b0);
    chk("int", TERM_INTERNAL, 34'h0000F);
  endtask
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    t_std();
    t_term();
    give_verdict();
  end
endmodule // lmrts_top_tb
`default_nettype wire
